// [design/pch_consts.svh]
/*
 * Offsets, reset values and fixed codes of the express
 * capability header register bank.
 * Assumes inclusion by bare name from the package and design modules.
 */
`ifndef PCH_CONSTS_SVH
`define PCH_CONSTS_SVH

// Byte addresses of the two registers
`define PCH_CAP_HDR_OFFSET      12'h040
`define PCH_DEV_CAP_OFFSET      12'h044

// Header fields
`define PCH_CAP_ID_VALUE        8'h10
`define PCH_NEXT_PTR_RESET      8'hC0
`define PCH_VERSION_RESET       4'h1
`define PCH_TYPE_UPSTREAM       4'h5
`define PCH_TYPE_DOWNSTREAM     4'h6
`define PCH_TC_ROUTING_RESET    1'h1
`define PCH_SLOT_RESET          1'h0

// Device capability fields
`define PCH_MAX_PAYLOAD_RESET   3'h1
`define PCH_EXT_TAG_RESET       1'h1
`define PCH_ROLE_ERR_VALUE      1'h1
`define PCH_POWER_SCALE_1P0     2'h0
`define PCH_POWER_SCALE_0P1     2'h1
`define PCH_POWER_SCALE_0P01    2'h2
`define PCH_POWER_SCALE_0P001   2'h3

`endif

// [design/pch_pkg.sv]
/*
 * Types shared by the express capability header register bank.
 * Assumes pch_consts.svh is on the include path.
 */
package pch_pkg;
`include "pch_consts.svh"

    // Bus request carried as one bundle
    typedef struct packed {
        logic        read;
        logic        write;
        logic [11:0] address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } pch_bus_req_type;

    // Slot power limit message as it arrives from the link layer
    typedef struct packed {
        logic       valid;
        logic [7:0] value;
        logic [1:0] scale;
    } pch_power_msg_type;

    // Bus slave handshake states
    typedef enum logic [0:0] {
        PCH_IDLE = 1'b0,
        PCH_DONE = 1'b1
    } pch_bus_state_type;

    // Complete state of the register bank
    typedef struct packed {
        pch_bus_state_type bus_state;
        logic [31:0]       readdata;
        logic              slot_implemented;
        logic [7:0]        next_pointer;
        logic [3:0]        structure_version;
        logic              traffic_class_routing_supported;
        logic [2:0]        max_payload_supported;
        logic              extended_tag_supported;
        logic [7:0]        captured_power_limit_value;
        logic [1:0]        captured_power_limit_scale;
    } pch_state_type;
endpackage

// [design/pch_power_scale.sv]
/*
 * Slot power limit scaler: turns captured value and scale into milliwatts.
 * Assumes value and scale are register outputs of the same clock domain.
 */
`timescale 1ns/1ps
`include "pch_consts.svh"
module pch_power_scale
    import pch_pkg::*;
(
    input  wire logic        mclk_in,       // Core clock
    input  wire logic        rstn_in,       // Synchronous reset, active low
    input  wire logic [7:0]  value_in,      // Captured limit value
    input  wire logic [1:0]  scale_in,      // Captured scale code
    output logic      [17:0] milliwatt_out  // Limit in milliwatts
);
    logic [17:0] mw_next;

    // Factor 1.0/0.1/0.01/0.001 as milliwatts per unit; keeps integer math exact
    always_comb begin
        unique case (scale_in)
            `PCH_POWER_SCALE_1P0:   mw_next = 18'(value_in) * 18'h003E8;
            `PCH_POWER_SCALE_0P1:   mw_next = 18'(value_in) * 18'h00064;
            `PCH_POWER_SCALE_0P01:  mw_next = 18'(value_in) * 18'h0000A;
            `PCH_POWER_SCALE_0P001: mw_next = 18'(value_in);
        endcase
    end

    // Registered so the top output comes from a flip-flop
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            milliwatt_out <= 18'h00000;
        end else begin
            milliwatt_out <= mw_next;
        end
    end
endmodule

// [design/pch_cap_regs.sv]
/*
 * Express capability header and device capabilities registers of one
 * switch port, reached over an Avalon-MM slave with waitrequest.
 * Assumes one core clock, synchronous active-low reset, and that the
 * link layer delivers a decoded slot power limit message as a one-cycle
 * pulse on the same clock.
 */
// Register access over Avalon-MM was chosen for this implementation.
// Function
// - Header low byte reads fixed identifier 0x10.
// - Bits 15:8 hold next pointer, reset 0xC0, writable only when unlocked.
// - Bits 19:16 report structure version, reset 0x1.
// - Port type reads 0x5 upstream, 0x6 downstream.
// - Bit 24 flags slot; resets zero, stays zero upstream.
// - Interrupt message number always reads zero.
// - Max payload supported set at initialisation, default 0x1 (256 bytes).
// - Phantom functions supported reads fixed zero.
// - Bit 5 extended tag support, reset one, writable only when unlocked.
// - Both exit latency fields read fixed zero.
// - Bit 15 role-based error reporting reads fixed one.
// - Upstream captures power value and scale from message; downstream reads zero.
// - Scale code 0..3 selects factor 1.0, 0.1, 0.01, 0.001.
// - Power limit equals captured value times selected scale factor.
`timescale 1ns/1ps
`include "pch_consts.svh"
module pch_cap_regs
    import pch_pkg::*;
#(
    parameter bit UPSTREAM = 1'b1        // Port role, selects type and capture
)(
    input  wire logic        mclk_in,             // Core clock, 40 MHz
    input  wire logic        rstn_in,             // Synchronous reset, active low
    input  wire logic [11:0] avs_address_in,      // Byte address
    input  wire logic        avs_read_in,         // Read request
    input  wire logic        avs_write_in,        // Write request
    input  wire logic [31:0] avs_writedata_in,    // Write data
    input  wire logic [3:0]  avs_byteenable_in,   // Byte lanes
    output logic      [31:0] avs_readdata_out,    // Read data
    output logic             avs_waitrequest_out, // Stall until answer ready
    input  wire logic        write_unlock_in,     // Device write lock open
    input  wire logic        power_msg_valid_in,  // Slot power message pulse
    input  wire logic [7:0]  power_msg_value_in,  // Message limit value
    input  wire logic [1:0]  power_msg_scale_in,  // Message scale code
    output logic      [7:0]  power_value_out,     // Captured limit value
    output logic      [1:0]  power_scale_out,     // Captured scale code
    output logic      [17:0] power_milliwatt_out  // Limit in milliwatts
);
    pch_state_type     state_reg;
    pch_state_type     state_next;
    pch_bus_req_type   req;
    pch_power_msg_type msg;
    logic [31:0]       hdr_word;
    logic [31:0]       dcap_word;
    logic [31:0]       wmask;
    logic [31:0]       hdr_wr;
    logic [31:0]       dcap_wr;
    logic              take;

    // Bundle the bus and message inputs
    assign req = '{read: avs_read_in, write: avs_write_in, address: avs_address_in,
                   writedata: avs_writedata_in, byteenable: avs_byteenable_in};
    assign msg = '{valid: power_msg_valid_in, value: power_msg_value_in,
                   scale: power_msg_scale_in};

    // Byte-lane mask so partial writes leave untouched lanes alone
    assign wmask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                    {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
    assign hdr_wr  = (req.writedata & wmask) | (hdr_word & ~wmask);
    assign dcap_wr = (req.writedata & wmask) | (dcap_word & ~wmask);

    // Header word as software sees it
    always_comb begin
        hdr_word        = 32'h00000000;
        hdr_word[7:0]   = `PCH_CAP_ID_VALUE;
        hdr_word[15:8]  = state_reg.next_pointer;
        hdr_word[19:16] = state_reg.structure_version;
        hdr_word[23:20] = UPSTREAM ? `PCH_TYPE_UPSTREAM
                                   : `PCH_TYPE_DOWNSTREAM;
        hdr_word[24]    = state_reg.slot_implemented;
        hdr_word[29:25] = 5'h00;
        hdr_word[30]    = state_reg.traffic_class_routing_supported;
    end

    // Device capabilities word as software sees it
    always_comb begin
        dcap_word        = 32'h00000000;
        dcap_word[2:0]   = state_reg.max_payload_supported;
        dcap_word[4:3]   = 2'h0;
        dcap_word[5]     = state_reg.extended_tag_supported;
        dcap_word[11:6]  = 6'h00;
        dcap_word[14:12] = 3'h0;
        dcap_word[15]    = `PCH_ROLE_ERR_VALUE;
        dcap_word[25:18] = state_reg.captured_power_limit_value;
        dcap_word[27:26] = state_reg.captured_power_limit_scale;
    end

    // A request is answered one cycle after it is first seen
    assign take = (req.read || req.write) && (state_reg.bus_state == PCH_IDLE);

    // Next-state logic for the whole bank
    always_comb begin
        state_next = state_reg;
        unique case (state_reg.bus_state)
            PCH_IDLE: begin
                if (take) begin
                    state_next.bus_state = PCH_DONE;
                end
            end
            PCH_DONE: begin
                state_next.bus_state = PCH_IDLE;
            end
        endcase
        // Read data latched at take, held through the answer cycle
        if (take && req.read) begin
            unique case (req.address)
                `PCH_CAP_HDR_OFFSET: state_next.readdata = hdr_word;
                `PCH_DEV_CAP_OFFSET: state_next.readdata = dcap_word;
                default:             state_next.readdata = 32'h00000000;
            endcase
        end
        // Writes land once, at take; lock closed means fields keep value
        if (take && req.write && write_unlock_in) begin
            if (req.address == `PCH_CAP_HDR_OFFSET) begin
                state_next.next_pointer      = hdr_wr[15:8];
                state_next.structure_version = hdr_wr[19:16];
                // Slot flag has no meaning upstream, so it is held at zero
                state_next.slot_implemented  = UPSTREAM ? 1'b0 : hdr_wr[24];
                state_next.traffic_class_routing_supported = hdr_wr[30];
            end
            if (req.address == `PCH_DEV_CAP_OFFSET) begin
                state_next.max_payload_supported  = dcap_wr[2:0];
                state_next.extended_tag_supported = dcap_wr[5];
            end
        end
        // Message capture only on the upstream port
        if (UPSTREAM && msg.valid) begin
            state_next.captured_power_limit_value = msg.value;
            state_next.captured_power_limit_scale = msg.scale;
        end
    end

    // Single register stage for all state
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            state_reg <= '{bus_state: PCH_IDLE,
                           readdata: 32'h00000000,
                           slot_implemented: `PCH_SLOT_RESET,
                           next_pointer: `PCH_NEXT_PTR_RESET,
                           structure_version: `PCH_VERSION_RESET,
                           traffic_class_routing_supported: `PCH_TC_ROUTING_RESET,
                           max_payload_supported: `PCH_MAX_PAYLOAD_RESET,
                           extended_tag_supported: `PCH_EXT_TAG_RESET,
                           captured_power_limit_value: 8'h00,
                           captured_power_limit_scale: 2'h0};
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops; waitrequest low only in answer cycle
    assign avs_readdata_out    = state_reg.readdata;
    assign avs_waitrequest_out = (state_reg.bus_state != PCH_DONE);
    assign power_value_out     = state_reg.captured_power_limit_value;
    assign power_scale_out     = state_reg.captured_power_limit_scale;

    // Milliwatt figure derived from captured fields
    pch_power_scale u_scale (
        .mclk_in       (mclk_in),
        .rstn_in       (rstn_in),
        .value_in      (state_reg.captured_power_limit_value),
        .scale_in      (state_reg.captured_power_limit_scale),
        .milliwatt_out (power_milliwatt_out)
    );
endmodule

// [tb/pch_cap_regs_assertions.sv]
/*
 * Checker for the capability header bank, bound to pch_cap_regs.
 * Assumes one core clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module pch_cap_checker
    import pch_pkg::*;
#(
    parameter bit UPSTREAM = 1'b1 // Port role of the watched bank
)(
    input wire logic        mclk_in,             // Core clock
    input wire logic        rstn_in,             // Reset, active low
    input wire logic [11:0] avs_address_in,      // Byte address
    input wire logic        avs_read_in,         // Read request
    input wire logic        avs_write_in,        // Write request
    input wire logic [31:0] avs_writedata_in,    // Write data
    input wire logic [3:0]  avs_byteenable_in,   // Byte lanes
    input wire logic [31:0] avs_readdata_out,    // Read data
    input wire logic        avs_waitrequest_out, // Stall
    input wire logic        write_unlock_in,     // Write lock open
    input wire logic        power_msg_valid_in,  // Message pulse
    input wire logic [7:0]  power_msg_value_in,  // Message value
    input wire logic [1:0]  power_msg_scale_in,  // Message scale
    input wire logic [7:0]  power_value_out,     // Captured value
    input wire logic [1:0]  power_scale_out,     // Captured scale
    input wire logic [17:0] power_milliwatt_out  // Limit in milliwatts
);
    // Scale code picks the divisor of a thousand
    function automatic logic [17:0] mw_of(input logic [7:0] v, input logic [1:0] s);
        return (s == 2'h0) ? 18'(v) * 18'h3E8 : (s == 2'h1) ? 18'(v) * 18'h64 :
               (s == 2'h2) ? 18'(v) * 18'h0A : 18'(v);
    endfunction
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    answer_one_wait_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("request not answered after one wait cycle");
    answer_pulse_a: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in)
        ##1 avs_waitrequest_out) else $error("answer without request or longer than one cycle");
    header_fixed_a: assert property (avs_read_in && !avs_waitrequest_out
        && avs_address_in == 12'h040 |-> avs_readdata_out[7:0] == 8'h10
        && avs_readdata_out[31] == 1'b0 && avs_readdata_out[29:25] == 5'h00
        && avs_readdata_out[23:20] == (UPSTREAM ? 4'h5 : 4'h6)
        && (!UPSTREAM || !avs_readdata_out[24])) else $error("header fixed field wrong");
    devcap_fixed_a: assert property (avs_read_in && !avs_waitrequest_out
        && avs_address_in == 12'h044 |-> avs_readdata_out[15:6] == 10'h200
        && avs_readdata_out[4:3] == 2'h0
        && avs_readdata_out[31:28] == 4'h0 && avs_readdata_out[17:16] == 2'h0
        && avs_readdata_out[27:18] == {$past(power_scale_out), $past(power_value_out)})
        else $error("device capability fixed field wrong");
    unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out
        && avs_address_in[11:3] != 9'h008 |-> avs_readdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    capture_load_a: assert property (power_msg_valid_in |=>
        power_value_out == (UPSTREAM ? $past(power_msg_value_in) : 8'h00)
        && power_scale_out == (UPSTREAM ? $past(power_msg_scale_in) : 2'h0))
        else $error("power message not captured");
    capture_hold_a: assert property (!power_msg_valid_in |=> $stable(power_value_out)
        && $stable(power_scale_out)) else $error("captured power changed without message");
    milliwatt_calc_a: assert property (power_milliwatt_out
        == mw_of($past(power_value_out), $past(power_scale_out))) else $error("milliwatt wrong");
endmodule
bind pch_cap_regs pch_cap_checker #(.UPSTREAM(UPSTREAM)) chk_i (.mclk_in(mclk_in),
    .rstn_in(rstn_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .write_unlock_in(write_unlock_in),
    .power_msg_valid_in(power_msg_valid_in), .power_msg_value_in(power_msg_value_in),
    .power_msg_scale_in(power_msg_scale_in), .power_value_out(power_value_out),
    .power_scale_out(power_scale_out), .power_milliwatt_out(power_milliwatt_out));

// [tb/pch_cap_regs_tb.sv]
/*
 * Self-checking bench for pch_cap_regs, upstream and downstream roles.
 * Assumes the bound checker and the package are compiled first.
 */
`timescale 1ns/1ps
module pch_cap_regs_tb import pch_pkg::*;;
    logic        mclk_in = 1'b0, rstn_in = 1'b0, rd_in = 1'b0, wr_in = 1'b0;
    logic        unl_in = 1'b0, pv_in = 1'b0, wait_out, wait_dn;
    logic [11:0] addr_in = 12'h000;
    logic [31:0] wd_in = 32'h0, rdat_out, rdat_dn, rnd = 32'h428A, hv, dv, he, hd, pw;
    logic [3:0]  be_in = 4'hF;
    logic [7:0]  pval_in = 8'h00, val_out, val_dn, cv = 8'h00;
    logic [1:0]  psc_in = 2'h0, sc_out, sc_dn, cs = 2'h0, pv_d = 2'b00;
    logic [17:0] mw_out, mw_dn;
    logic [31:0] exp_q[$], dn_q[$], pw_q[$];
    int          n_fail = 0, samples_checked = 0, mult[4] = '{1000, 100, 10, 1};
    always #12.5 mclk_in = ~mclk_in;
    pch_cap_regs #(.UPSTREAM(1'b1)) uut (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .avs_address_in(addr_in), .avs_read_in(rd_in), .avs_write_in(wr_in),
        .avs_writedata_in(wd_in), .avs_byteenable_in(be_in), .avs_readdata_out(rdat_out),
        .avs_waitrequest_out(wait_out), .write_unlock_in(unl_in), .power_msg_valid_in(pv_in),
        .power_msg_value_in(pval_in), .power_msg_scale_in(psc_in), .power_value_out(val_out),
        .power_scale_out(sc_out), .power_milliwatt_out(mw_out));
    // Downstream role on the same bus: type 6, writable slot, no capture
    pch_cap_regs #(.UPSTREAM(1'b0)) uut_dn (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .avs_address_in(addr_in), .avs_read_in(rd_in), .avs_write_in(wr_in),
        .avs_writedata_in(wd_in), .avs_byteenable_in(be_in), .avs_readdata_out(rdat_dn),
        .avs_waitrequest_out(wait_dn), .write_unlock_in(unl_in), .power_msg_valid_in(pv_in),
        .power_msg_value_in(pval_in), .power_msg_scale_in(psc_in), .power_value_out(val_dn),
        .power_scale_out(sc_dn), .power_milliwatt_out(mw_dn));
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    // Expected words; upstream slot bit and bit 31 never take writes
    function automatic logic [31:0] hdr(input logic [31:0] d, input logic up);
        return {1'b0, d[30], 5'h00, up ? 1'b0 : d[24], up ? 4'h5 : 4'h6, d[19:16], d[15:8],
                8'h10};
    endfunction
    // Downstream never captures, so its power fields stay zero
    function automatic logic [31:0] dcap(input logic [31:0] d, input logic up);
        return {4'h0, up ? cs : 2'h0, up ? cv : 8'h00, 2'h0, 1'b1, 9'h000, d[5], 2'h0, d[2:0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        // A note never answered is a lost result
        if (exp_q.size() + dn_q.size() + pw_q.size() != 0) n_fail++;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One access; held until waitrequest is seen low, bounded wait
    task automatic bus(input logic r, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int i;
        rd_in <= r;
        wr_in <= !r;
        addr_in <= a;
        wd_in <= d;
        be_in <= b;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_in);
            if (wait_out === 1'b0) break;
        end
        if (i == 20) begin
            n_fail++;
            conclude();
        end else begin
            rd_in <= 1'b0;
            wr_in <= 1'b0;
            @(posedge mclk_in);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] en);
        exp_q.push_back(e);
        dn_q.push_back(en);
        bus(1'b1, a, 32'h0, 4'hF);
    endtask
    // Monitor takes the oldest note when read data or a captured message appear
    always @(posedge mclk_in) begin
        if (rstn_in && rd_in && wait_out === 1'b0) chk(rdat_out, exp_q.pop_front());
        if (rstn_in && rd_in && wait_dn === 1'b0) chk(rdat_dn, dn_q.pop_front());
        // Milliwatts settle two edges after the message pulse
        if (pv_d[1]) begin
            chk({22'h0, sc_out, val_out}, pw_q.pop_front());
            chk({14'h0, mw_out}, pw_q.pop_front());
            chk({4'h0, mw_dn, sc_dn, val_dn}, pw_q.pop_front());
        end
        pv_d <= {pv_d[0], pv_in};
    end
    initial begin
        repeat (3) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        rd(12'h040, 32'h4051C010, 32'h4061C010);
        rd(12'h044, dcap(32'h21, 1'b1), dcap(32'h21, 1'b0));
        rd(12'h048, 32'h0, 32'h0);
        bus(1'b0, 12'h040, 32'hFFFFFFFF, 4'hF);
        rd(12'h040, 32'h4051C010, 32'h4061C010);
        unl_in <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            hv = xs();
            dv = xs();
            bus(1'b0, 12'h040, hv, 4'hF);
            bus(1'b0, 12'h044, dv, 4'hF);
            rd(12'h040, hdr(hv, 1'b1), hdr(hv, 1'b0));
            rd(12'h044, dcap(dv, 1'b1), dcap(dv, 1'b0));
        end
        // Only the lane of the next pointer may change; other lanes carry noise
        pw = xs();
        bus(1'b0, 12'h040, {pw[31:16], ~hv[15:8], pw[7:0]}, 4'h2);
        he = hdr(hv, 1'b1);
        hd = hdr(hv, 1'b0);
        rd(12'h040, {he[31:16], ~hv[15:8], 8'h10}, {hd[31:16], ~hv[15:8], 8'h10});
        for (int s = 0; s < 4; s++) begin
            cv = 8'(xs());
            cs = 2'(s);
            pw_q.push_back({22'h0, cs, cv});
            pw_q.push_back(32'(cv * mult[s]));
            pw_q.push_back(32'h0);
            pv_in <= 1'b1;
            pval_in <= cv;
            psc_in <= cs;
            @(posedge mclk_in);
            pv_in <= 1'b0;
            repeat (2) @(posedge mclk_in);
            rd(12'h044, dcap(dv, 1'b1), dcap(dv, 1'b0));
        end
        // Reset again in mid-run clears capture and writes
        rstn_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        rstn_in <= 1'b1;
        cv = 8'h00;
        cs = 2'h0;
        @(posedge mclk_in);
        rd(12'h044, dcap(32'h21, 1'b1), dcap(32'h21, 1'b0));
        rd(12'h040, 32'h4051C010, 32'h4061C010);
        conclude();
    end
endmodule
